// [core/stepper_indexer_cfg.svh]
// constants of the stepper indexer control block
`ifndef STEPPER_INDEXER_CFG_SVH
`define STEPPER_INDEXER_CFG_SVH

// ****************************************
// register map (byte addresses)
// ****************************************
`define REG_STATUS      8'h00
`define REG_CONTROL     8'h04
`define REG_STEPCOUNT   8'h08

// ****************************************
// status field positions
// ****************************************
`define ST_INDEX_LSB    0
`define ST_OC_BIT       8
`define ST_HOT_BIT      9
`define ST_UV_BIT       10
`define ST_SLEEP_BIT    11
`define ST_BRIDGE_BIT   12
`define ST_RESET_BIT    13

// ****************************************
// reset values and table
// ****************************************
`define HOME_INDEX      7'h10
`define FAULT_IDLE      1'b1

// ****************************************
// timing
// ****************************************
`define CLK_PERIOD_NS   25
`define OC_TIME_NS      3000
`define OC_QUAL_CYCLES  ((`OC_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define HOT_TRIP_DEGC   150

`endif

// [core/stepper_indexer_pkg.sv]
// types of the stepper indexer control block
`include "stepper_indexer_cfg.svh"

package stepper_indexer_pkg;

  // power state of the device
  typedef enum logic [1:0] {
    run_state,
    sleep_state,
    lockout_state
  } power_type;

  // whole registered state of the block
  typedef struct packed {
    logic [6:0]  step_index;
    logic        step_prev;
    logic [15:0] oc_count;
    logic [15:0] oc_qual;
    logic        oc_latched;
    logic [15:0] step_count;
    power_type   power;
    logic        bridge_enable;
    logic        charge_pump_run;
    logic        regulator_on;
    logic        clocks_run;
    logic        fault_flag_low;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } state_type;

endpackage

// [core/stepper_indexer_control.sv]
// indexer, enable/sleep/reset and protection logic with apb status
`timescale 1ns/1ps
`default_nettype none
`include "stepper_indexer_cfg.svh"

module stepper_indexer_control
  import stepper_indexer_pkg::*;
#(
  parameter int ADDR_WIDTH = 8,
  parameter int FET_COUNT  = 8
) (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  ce,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [ADDR_WIDTH-1:0] paddr,
  input  wire logic [31:0]           pwdata,
  output var  logic [31:0]           prdata,
  output var  logic                  pready,
  output var  logic                  pslverr,
  input  wire logic                  logic_reset_low,
  input  wire logic                  output_enable_low,
  input  wire logic                  sleep_request_low,
  input  wire logic                  step_pulse,
  input  wire logic                  direction_fwd,
  input  wire logic [2:0]            step_mode,
  input  wire logic [FET_COUNT-1:0]  fet_current_limit,
  input  wire logic                  thermal_hot,
  input  wire logic                  undervoltage_lockout,
  output var  logic                  bridge_enable,
  output var  logic                  charge_pump_run,
  output var  logic                  internal_regulator_out,
  output var  logic                  clocks_run,
  output var  logic                  fault_flag_low,
  output var  logic [6:0]            step_index
);

  // ****************************************
  // elaboration checks
  // ****************************************
  generate
    if (ADDR_WIDTH < 8 || ADDR_WIDTH > 32) begin : g_bad_addr
      $error("ADDR_WIDTH must be 8 to 32");
    end
    if (FET_COUNT < 1) begin : g_bad_fet
      $error("FET_COUNT must be at least 1");
    end
  endgenerate

  // ****************************************
  // state and reset value
  // ****************************************
  localparam state_type RESET_STATE = '{
    step_index      : `HOME_INDEX,
    step_prev       : 1'b0,
    oc_count        : 16'h0000,
    oc_qual         : 16'(`OC_QUAL_CYCLES),
    oc_latched      : 1'b0,
    step_count      : 16'h0000,
    power           : lockout_state,
    bridge_enable   : 1'b0,
    charge_pump_run : 1'b0,
    regulator_on    : 1'b0,
    clocks_run      : 1'b0,
    fault_flag_low  : `FAULT_IDLE,
    prdata          : 32'h0000_0000,
    pready          : 1'b0,
    pslverr         : 1'b0
  };

  state_type r;
  state_type next_r;

  logic [6:0] step_incr;
  logic [6:0] step_target;
  logic       limit_any;
  logic       step_rise;
  logic       step_ok;
  logic [7:0] reg_addr;
  logic [31:0] addr_full;
  logic        addr_high;

  // ****************************************
  // indexer step size and target
  // ****************************************
  always_comb begin
    // coarser modes jump by powers of two across the 128-entry table
    case (step_mode)
      3'd0:    step_incr = 7'h20;
      3'd1:    step_incr = 7'h10;
      3'd2:    step_incr = 7'h08;
      3'd3:    step_incr = 7'h04;
      3'd4:    step_incr = 7'h02;
      default: step_incr = 7'h01;
    endcase
  end

  // modulo-128 arithmetic gives circular wrap in both directions
  assign step_target = direction_fwd ? r.step_index + step_incr
                                     : r.step_index - step_incr;
  assign limit_any   = |fet_current_limit;
  assign step_rise   = step_pulse && !r.step_prev;
  assign reg_addr    = paddr[7:0];
  // zero-extend so the upper-bit test also holds for an 8-bit bus
  assign addr_full   = 32'(paddr);
  assign addr_high   = (addr_full[31:8] != 24'h00_0000);

  // steps count only when the bridges could legally drive
  assign step_ok = logic_reset_low && !output_enable_low
                && !r.oc_latched && !thermal_hot;

  // ****************************************
  // next-state logic
  // ****************************************
  always_comb begin
    next_r = r;
    // edge detector tracks the pin in every power state, so a level
    // already high at wake or release does not count as a step
    next_r.step_prev = step_pulse;

    if (undervoltage_lockout) begin
      // supply loss clears the overcurrent latch as well
      next_r.power           = lockout_state;
      next_r.step_index      = `HOME_INDEX;
      next_r.oc_latched      = 1'b0;
      next_r.oc_count        = 16'h0000;
      next_r.bridge_enable   = 1'b0;
      next_r.charge_pump_run = 1'b0;
      next_r.regulator_on    = 1'b0;
      next_r.clocks_run      = 1'b0;
      next_r.fault_flag_low  = `FAULT_IDLE;
    end else if (!sleep_request_low) begin
      // clocks halted: indexer, timer and fault all frozen
      next_r.power           = sleep_state;
      next_r.bridge_enable   = 1'b0;
      next_r.charge_pump_run = 1'b0;
      next_r.regulator_on    = 1'b0;
      next_r.clocks_run      = 1'b0;
    end else begin
      next_r.power           = run_state;
      next_r.charge_pump_run = 1'b1;
      next_r.regulator_on    = 1'b1;
      next_r.clocks_run      = 1'b1;
      if (!logic_reset_low) begin
        // reset input and supply loss are the only exits from a latched overcurrent
        next_r.step_index = `HOME_INDEX;
        next_r.oc_latched = 1'b0;
        next_r.oc_count   = 16'h0000;
      end else begin
        // qualify the current limit before shutting the bridges; a glitch
        // shorter than the qualification time restarts the count from zero
        if (!limit_any) begin
          next_r.oc_count = 16'h0000;
        end else if (r.oc_count >= r.oc_qual) begin
          next_r.oc_latched = 1'b1;
        end else begin
          next_r.oc_count = r.oc_count + 16'h0001;
        end
        if (step_rise && step_ok) begin
          next_r.step_index = step_target;
          next_r.step_count = r.step_count + 16'h0001;
        end
      end
      // thermal comparator trips near HOT_TRIP_DEGC and self-clears
      next_r.fault_flag_low = !(next_r.oc_latched || thermal_hot);
      next_r.bridge_enable  = logic_reset_low && !output_enable_low
                           && !next_r.oc_latched && !thermal_hot;
    end

    // apb: answer in the access cycle, no wait states
    next_r.pready = psel && !penable;
    if (psel && !penable) begin
      next_r.pslverr = 1'b0;
      case (reg_addr)
        `REG_STATUS: begin
          next_r.prdata = {18'h0_0000,
                           !logic_reset_low,
                           r.bridge_enable,
                           r.power == sleep_state,
                           undervoltage_lockout,
                           thermal_hot,
                           r.oc_latched,
                           1'b0,
                           r.step_index};
        end
        `REG_CONTROL: begin
          next_r.prdata = {16'h0000, r.oc_qual};
        end
        `REG_STEPCOUNT: begin
          next_r.prdata = {16'h0000, r.step_count};
        end
        default: begin
          next_r.prdata  = 32'h0000_0000;
          next_r.pslverr = 1'b1;
        end
      endcase
      // upper address bits alias nothing, so they are refused outright
      if (addr_high) begin
        next_r.prdata  = 32'h0000_0000;
        next_r.pslverr = 1'b1;
      end
    end else if (!psel) begin
      next_r.pslverr = 1'b0;
    end
    // writes land only at the completing access edge
    if (psel && penable && r.pready && pwrite && !r.pslverr
        && reg_addr == `REG_CONTROL) begin
      next_r.oc_qual = pwdata[15:0];
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= RESET_STATE;
    end else if (ce) begin
      r <= next_r;
    end
  end

  // outputs straight from the state flops
  assign prdata                 = r.prdata;
  assign pready                 = r.pready;
  assign pslverr                = r.pslverr;
  assign bridge_enable          = r.bridge_enable;
  assign charge_pump_run        = r.charge_pump_run;
  assign internal_regulator_out = r.regulator_on;
  assign clocks_run             = r.clocks_run;
  assign fault_flag_low         = r.fault_flag_low;
  assign step_index             = r.step_index;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // an input rising edge while the device may step
  sequence step_edge_s;
    ce && !step_pulse ##1 ce && step_pulse && sleep_request_low
      && !undervoltage_lockout && step_ok;
  endsequence

  // awake and supplied, whatever the reset input
  sequence awake_s;
    ce && sleep_request_low && !undervoltage_lockout;
  endsequence

  reset_home_a: assert property (
    awake_s and !logic_reset_low |=> step_index == `HOME_INDEX && !r.oc_latched)
    else $error("reset input did not home the indexer");

  reset_bridge_a: assert property (
    awake_s and !logic_reset_low |=> !bridge_enable)
    else $error("bridge driven while reset held");

  reset_step_a: assert property (
    ce && !logic_reset_low ##1 ce && !logic_reset_low |=> $stable(r.step_count))
    else $error("step counted while reset held");

  enable_run_a: assert property (
    awake_s and logic_reset_low && !output_enable_low && !thermal_hot
      && !r.oc_latched && !limit_any |=> bridge_enable)
    else $error("enabled device left bridges off");

  enable_off_a: assert property (
    ce && output_enable_low |=> !bridge_enable && $stable(r.step_count))
    else $error("disabled device drove or stepped");

  sleep_off_a: assert property (
    ce && !sleep_request_low |=> !bridge_enable && !charge_pump_run
      && !internal_regulator_out && !clocks_run)
    else $error("sleep left circuitry running");

  sleep_ignore_a: assert property (
    ce && !sleep_request_low && !undervoltage_lockout |=> $stable(step_index)
      && $stable(fault_flag_low) && $stable(r.oc_latched))
    else $error("input acted during sleep");

  oc_trip_a: assert property (
    awake_s and logic_reset_low && limit_any && r.oc_count >= r.oc_qual
      |=> r.oc_latched && !bridge_enable && !fault_flag_low)
    else $error("overcurrent did not shut down");

  oc_hold_a: assert property (
    r.oc_latched && ce && logic_reset_low && !undervoltage_lockout
      |=> r.oc_latched)
    else $error("overcurrent latch dropped by itself");

  hot_trip_a: assert property (
    awake_s and thermal_hot |=> !bridge_enable && !fault_flag_low)
    else $error("over-temperature not acted on");

  // over-temperature seen while awake
  sequence hot_s;
    awake_s and thermal_hot;
  endsequence

  // cooled, with no latched trip and no live current limit
  sequence cool_s;
    awake_s and !thermal_hot && !r.oc_latched && logic_reset_low && !limit_any;
  endsequence

  hot_resume_a: assert property (
    hot_s ##1 cool_s |=> fault_flag_low)
    else $error("no recovery after cooling");

  uv_reset_a: assert property (
    ce && undervoltage_lockout |=> step_index == `HOME_INDEX && !bridge_enable
      && !internal_regulator_out && fault_flag_low && !r.oc_latched)
    else $error("undervoltage did not reset logic");

  uv_resume_a: assert property (
    ce && undervoltage_lockout ##1 awake_s |=> clocks_run && charge_pump_run)
    else $error("no resume after supply recovery");

  step_move_a: assert property (
    step_edge_s |=> step_index == $past(step_target))
    else $error("indexer moved wrongly on a step");

  // mode and direction are judged at the edge that is taken
  full_step_a: assert property (
    step_edge_s ##0 (step_mode == 3'd0 && direction_fwd)
      |=> step_index == 7'($past(step_index) + 7'h20))
    else $error("full step size wrong");

  // backward full step, the mirror of the forward case
  back_step_a: assert property (
    step_edge_s ##0 (step_mode == 3'd0 && !direction_fwd)
      |=> step_index == 7'($past(step_index) - 7'h20))
    else $error("backward step size wrong");

  // finest mode moves a single table entry
  fine_step_a: assert property (
    step_edge_s ##0 (step_mode >= 3'h5 && direction_fwd)
      |=> step_index == 7'($past(step_index) + 7'h01))
    else $error("finest step size wrong");

  // reset pin clears a latched trip and releases the fault output
  reset_fault_a: assert property (
    awake_s and !logic_reset_low && !thermal_hot |=> fault_flag_low)
    else $error("fault held through reset");

  // zero wait states: every access phase is answered at once
  apb_ready_a: assert property (
    ce && psel && !penable |=> pready)
    else $error("access phase not answered");

  // upper address bits set give an error and no data
  apb_error_a: assert property (
    ce && psel && !penable && addr_high |=> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not refused");

  // control write lands at the completing edge
  apb_write_a: assert property (
    ce && psel && penable && pready && pwrite && !pslverr && reg_addr == `REG_CONTROL
      |=> r.oc_qual == $past(pwdata[15:0]))
    else $error("control write lost");

endmodule

`default_nettype wire

// [test/step_source.sv]
// step and direction source standing in for the motion controller
`timescale 1ns/1ps
`default_nettype none

module step_source #(
  parameter int WAKE_CYCLES = 40000
) (
  input  wire logic       pclk,
  input  wire logic       sleep_request_low,
  input  wire logic       go,
  input  wire logic [7:0] n_req,
  input  wire logic       dir_req,
  output var  logic       step_pulse,
  output var  logic       direction_fwd,
  output var  logic       busy
);
  int         wake_cnt = 0;
  logic [7:0] left     = 8'h00;

  initial begin
    step_pulse = 1'b0;
    direction_fwd = 1'b1;
  end

  // pulses high one cycle, low one cycle; direction settles before the edge
  always @(posedge pclk) begin
    if (!sleep_request_low) begin
      wake_cnt <= 0;
    end else if (wake_cnt < WAKE_CYCLES) begin
      wake_cnt <= wake_cnt + 1;
    end
    if (go) begin
      left <= n_req;
      direction_fwd <= dir_req;
    end else if (step_pulse) begin
      step_pulse <= 1'b0;
    end else if (left != 8'h00 && wake_cnt == WAKE_CYCLES) begin
      step_pulse <= 1'b1;
      left <= left - 8'h01;
    end
  end

  assign busy = (left != 8'h00) || step_pulse;
endmodule

`default_nettype wire

// [test/tb_top.sv]
// self-checking bench for the stepper indexer control block
`timescale 1ns/1ps
`default_nettype none
`include "stepper_indexer_cfg.svh"

module tb_top;
  // ****************************************
  // signals
  // ****************************************
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        rst_low = 1'b1;
  logic        oe_low = 1'b0;
  logic        sleep_low = 1'b1;
  logic        step_pulse;
  logic        dir_fwd;
  logic [2:0]  step_mode = 3'h0;
  logic [7:0]  fet = 8'h00;
  logic        hot = 1'b0;
  logic        uv = 1'b0;
  logic        bridge, pump, regul, clk_run, fault_low;
  logic [6:0]  step_index;
  logic        go = 1'b0;
  logic [7:0]  n_req = 8'h00;
  logic        dir_req = 1'b1;
  logic        busy;
  logic [6:0]  exp_idx = 7'h10;
  logic [31:0] q;
  logic        e;
  int          err_count = 0;
  int          n_tests = 0;
  int          acc = 0;

  always #12.5 pclk = ~pclk;

  stepper_indexer_control dut_u (
    .pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .logic_reset_low(rst_low), .output_enable_low(oe_low), .sleep_request_low(sleep_low),
    .step_pulse(step_pulse), .direction_fwd(dir_fwd), .step_mode(step_mode),
    .fet_current_limit(fet), .thermal_hot(hot), .undervoltage_lockout(uv),
    .bridge_enable(bridge), .charge_pump_run(pump), .internal_regulator_out(regul),
    .clocks_run(clk_run), .fault_flag_low(fault_low), .step_index(step_index));

  // wake gap shortened from 1 ms so the run stays short
  step_source #(.WAKE_CYCLES(40)) src_u (
    .pclk(pclk), .sleep_request_low(sleep_low), .go(go), .n_req(n_req), .dir_req(dir_req),
    .step_pulse(step_pulse), .direction_fwd(dir_fwd), .busy(busy));

  // ****************************************
  // tasks
  // ****************************************
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      err_count++;
      final_report();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // outputs follow inputs one cycle late; three cycles leave margin
  task automatic settle;
    repeat (3) @(posedge pclk);
  endtask

  function automatic logic [6:0] inc(input logic [2:0] m);
    return (m >= 3'h5) ? 7'h01 : (7'h20 >> m);
  endfunction

  // request n steps; ok says whether the indexer must move
  task automatic steps(input int n, input logic dir, input logic ok);
    int k;
    @(posedge pclk);
    go <= 1'b1;
    n_req <= 8'(n);
    dir_req <= dir;
    @(posedge pclk);
    go <= 1'b0;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (busy !== 1'b0 && k < 200);
    if (busy !== 1'b0) begin
      err_count++;
      final_report();
    end
    settle();
    for (int i = 0; i < n && ok; i++) begin
      exp_idx = dir ? exp_idx + inc(step_mode) : exp_idx - inc(step_mode);
      acc++;
    end
    check("step_index", 32'(step_index), 32'(exp_idx));
  endtask

  task automatic pins(input logic [4:0] exp);
    check("outputs", 32'({bridge, pump, regul, clk_run, fault_low}), 32'(exp));
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    settle();
    check("home", 32'(step_index), 32'h0000_0010);
    pins(5'h1F);
    apb(1'b0, `REG_CONTROL, 32'h0000_0000);
    check("control", q, 32'h0000_0078);
    apb(1'b0, 8'h0C, 32'h0000_0000);
    check("unmapped", {q[30:0], e}, 32'h0000_0001);
    $display("test reset done");
    // every mode once, then wrap both ways at full step
    for (int m = 0; m < 8; m++) begin
      step_mode <= 3'(m);
      steps(1, 1'b1, 1'b1);
    end
    step_mode <= 3'h0;
    steps(3, 1'b1, 1'b1);
    steps(3, 1'b0, 1'b1);
    $display("test stepping done");
    rst_low <= 1'b0;
    settle();
    exp_idx = 7'h10;
    check("reset_home", 32'(step_index), 32'(exp_idx));
    check("reset_bridge", 32'(bridge), 32'h0000_0000);
    steps(2, 1'b1, 1'b0);
    rst_low <= 1'b1;
    oe_low <= 1'b1;
    settle();
    check("oe_bridge", 32'(bridge), 32'h0000_0000);
    steps(2, 1'b1, 1'b0);
    oe_low <= 1'b0;
    steps(1, 1'b1, 1'b1);
    $display("test pins done");
    sleep_low <= 1'b0;
    rst_low <= 1'b0;
    settle();
    pins(5'h01);
    check("sleep_index", 32'(step_index), 32'(exp_idx));
    apb(1'b0, `REG_STATUS, 32'h0000_0000);
    check("status_sleep", q, 32'h0000_2830);
    rst_low <= 1'b1;
    sleep_low <= 1'b1;
    settle();
    pins(5'h1F);
    steps(1, 1'b0, 1'b1);
    $display("test sleep done");
    apb(1'b1, `REG_CONTROL, 32'h0000_0004);
    apb(1'b0, `REG_CONTROL, 32'h0000_0000);
    check("control_wr", q, 32'h0000_0004);
    for (int b = 0; b < 8; b += 7) begin
      fet[b] <= 1'b1;
      repeat (3) @(posedge pclk);
      fet <= 8'h00;
      settle();
      pins(5'h1F);
      fet[b] <= 1'b1;
      repeat (8) @(posedge pclk);
      fet <= 8'h00;
      settle();
      pins(5'h0E);
      apb(1'b0, `REG_STATUS, 32'h0000_0000);
      check("status_oc", q, 32'h0000_0110);
      steps(1, 1'b1, 1'b0);
      rst_low <= 1'b0;
      settle();
      rst_low <= 1'b1;
      settle();
      exp_idx = 7'h10;
      pins(5'h1F);
    end
    $display("test overcurrent done");
    hot <= 1'b1;
    settle();
    pins(5'h0E);
    apb(1'b0, `REG_STATUS, 32'h0000_0000);
    check("status_hot", q, 32'h0000_0210);
    steps(1, 1'b1, 1'b0);
    hot <= 1'b0;
    settle();
    pins(5'h1F);
    steps(1, 1'b1, 1'b1);
    uv <= 1'b1;
    settle();
    exp_idx = 7'h10;
    check("uv_index", 32'(step_index), 32'(exp_idx));
    check("uv_outs", 32'({bridge, pump, regul, clk_run}), 32'h0000_0000);
    uv <= 1'b0;
    settle();
    pins(5'h1F);
    steps(1, 1'b1, 1'b1);
    apb(1'b0, `REG_STEPCOUNT, 32'h0000_0000);
    check("stepcount", q, 32'(acc));
    $display("test faults done");
    final_report();
  end
endmodule

`default_nettype wire
